// ===== design/lsc_pkg.sv
// lsc_pkg: register map, reset values and timing constants of the light sensor
package lsc_pkg;
   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_ON_OFF = 4'h0;
   localparam logic [3:0] ADDR_SETUP = 4'h1;
   localparam logic [3:0] ADDR_LO_LSB = 4'h2;
   localparam logic [3:0] ADDR_LO_MSB = 4'h3;
   localparam logic [3:0] ADDR_HI_LSB = 4'h4;
   localparam logic [3:0] ADDR_HI_MSB = 4'h5;
   // ------------------------------------------------------------
   // reset values and field codes
   // ------------------------------------------------------------
   localparam logic [7:0] RST_ON_OFF = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h02;
   localparam logic [7:0] RST_LIMIT = 8'h00;
   localparam logic [7:0] RST_CMD = 8'h00;
   localparam logic [1:0] POWER_UP = 2'h3;
   localparam logic [1:0] POWER_DOWN = 2'h0;
   localparam logic [1:0] PERIOD_SHORT = 2'h0;
   localparam logic [1:0] PERIOD_MID = 2'h1;
   localparam logic [1:0] PERIOD_LONG = 2'h2;
   localparam logic [1:0] PERIOD_MANUAL = 2'h3;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CMD_SEL_BIT = 7;
   localparam int CMD_CLEAR_BIT = 6;
   localparam int CMD_WORD_BIT = 5;
   localparam int CMD_BLOCK_BIT = 4;
   localparam int GAIN_BIT = 4;
   localparam int MANUAL_BIT = 3;
   // ------------------------------------------------------------
   // integration periods, times in microseconds
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int T_SHORT_US = 13700;
   localparam int T_MID_US = 101000;
   localparam int T_LONG_US = 402000;
   // whole cycles of the internal clock
   localparam int CYC_SHORT = T_SHORT_US * CLK_MHZ;
   localparam int CYC_MID = T_MID_US * CLK_MHZ;
   localparam int CYC_LONG = T_LONG_US * CLK_MHZ;
   localparam int CNT_W = 24;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } lsc_tmr_state_t;
endpackage : lsc_pkg

// ===== design/lsc_intg_if.sv
// lsc_intg_if: integration and threshold signals between control modules
`timescale 1ns/1ps
interface lsc_intg_if;
   logic power_on;
   logic [1:0] period_sel;
   logic manual;
   logic done;
   logic running;
   logic [15:0] result;
   logic [15:0] lo_limit;
   logic [15:0] hi_limit;
   logic limit_evt;
   modport timer (
      input power_on, period_sel, manual,
      output done, running
   );
   modport cmp (
      input done, result, lo_limit, hi_limit,
      output limit_evt
   );
   modport ctrl (
      output power_on, period_sel, manual, result, lo_limit, hi_limit,
      input done, running, limit_evt
   );
endinterface : lsc_intg_if

// ===== design/lsc_intg_timer.sv
// lsc_intg_timer: fixed and manual integration period sequencer
`timescale 1ns/1ps
module lsc_intg_timer #(
   parameter int CYC_SHORT = lsc_pkg::CYC_SHORT,
   parameter int CYC_MID = lsc_pkg::CYC_MID,
   parameter int CYC_LONG = lsc_pkg::CYC_LONG
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   lsc_intg_if.timer bus
);
   localparam int W = lsc_pkg::CNT_W;
   lsc_pkg::lsc_tmr_state_t state;
   lsc_pkg::lsc_tmr_state_t next_state;
   logic [W-1:0] cnt;
   logic [W-1:0] last;
   logic auto_mode;
   logic finish;
   logic done_q;

   // ------------------------------------------------------------
   // period selection
   // ------------------------------------------------------------
   assign auto_mode = bus.period_sel != lsc_pkg::PERIOD_MANUAL;
   assign last = (bus.period_sel == lsc_pkg::PERIOD_SHORT) ?
                 W'(CYC_SHORT - 1) :
                 (bus.period_sel == lsc_pkg::PERIOD_MID) ?
                 W'(CYC_MID - 1) : W'(CYC_LONG - 1);
   // manual bit only counts in the manual code; >= so that a switch to a
   // shorter period mid-count ends at once instead of wrapping the counter
   assign finish = auto_mode ? (cnt >= last) : !bus.manual;

   always_comb
   begin
      next_state = state;
      unique case (state)
         lsc_pkg::ST_IDLE:
            if (bus.power_on && (auto_mode || bus.manual))
               next_state = lsc_pkg::ST_RUN;
         lsc_pkg::ST_RUN:
            if (!bus.power_on || (!auto_mode && !bus.manual))
               next_state = lsc_pkg::ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // state, count and completion pulse
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= lsc_pkg::ST_IDLE;
         cnt <= '0;
         done_q <= 1'b0;
      end
      else if (i_ce)
      begin
         state <= next_state;
         done_q <= (state == lsc_pkg::ST_RUN) && bus.power_on && finish;
         if (state != lsc_pkg::ST_RUN || finish)
            cnt <= '0;
         else
            cnt <= cnt + W'(1);
      end
   end

   assign bus.done = done_q;
   assign bus.running = state == lsc_pkg::ST_RUN;
endmodule : lsc_intg_timer

// ===== design/lsc_limit_cmp.sv
// lsc_limit_cmp: channel 0 window comparison at end of integration
`timescale 1ns/1ps
module lsc_limit_cmp (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   lsc_intg_if.cmp bus
);
   logic below;
   logic above;
   logic evt;

   assign below = bus.result <= bus.lo_limit;
   assign above = bus.result > bus.hi_limit;

   // compared only on the completion pulse
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         evt <= 1'b0;
      else if (i_ce)
         evt <= bus.done && (below || above);
   end

   assign bus.limit_evt = evt;
endmodule : lsc_limit_cmp

// ===== design/lsc_light_ctrl.sv
// lsc_light_ctrl: register file, integration control and threshold interrupt
//
// Summary of operation
// - writing 03h to power field powers up
// - writing 00h to control powers down
// - control reads back 03h after writing 03h
// - setup register resets to 02h
// - setup bit 4 selects 1x or 16x gain
// - manual bit starts and stops integration
// - manual bit ignored unless period code 11
// - period codes give 13.7, 101, 402 ms
// - periods derived from the internal clock
// - interrupt when channel 0 at or below lower
// - interrupt when channel 0 above upper limit
// - limits are byte pairs at 2h/3h, 4h/5h
// - limit bytes reset to 00h
// - first byte with MSB set is command
// - command bit 7 select, bits 3:0 address
// - interrupt low until command with clear bit
`timescale 1ns/1ps
module lsc_light_ctrl #(
   parameter int CYC_SHORT = lsc_pkg::CYC_SHORT,
   parameter int CYC_MID = lsc_pkg::CYC_MID,
   parameter int CYC_LONG = lsc_pkg::CYC_LONG
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_xfer_start,
   input wire logic i_wr_stb,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_stb,
   input wire logic [15:0] i_ch0_result,
   output logic [7:0] o_rd_data,
   output logic o_int_n,
   output logic o_power_on,
   output logic o_gain_high,
   output logic o_integrating
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [3:0] cmd_addr;
   logic cmd_word;
   logic cmd_block;
   logic first_byte;
   logic [1:0] power;
   logic gain;
   logic manual;
   logic [1:0] period;
   logic [15:0] lo_limit;
   logic [15:0] hi_limit;
   logic [15:0] res_s1;
   logic [15:0] res_s2;

   lsc_intg_if intg ();

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction : hit

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic cmd_take;
   logic data_wr;
   logic step;
   logic clr_req;
   logic wr_on_off;
   logic wr_setup;
   logic wr_lo_lsb;
   logic wr_lo_msb;
   logic wr_hi_lsb;
   logic wr_hi_msb;
   logic [3:0] next_cmd_addr;
   logic [7:0] rd_mux;
   logic [7:0] on_off_byte;
   logic [7:0] setup_byte;
   logic next_int_n;

   // a lone byte with bit 7 set is a command, never data
   assign cmd_take = i_wr_stb && first_byte &&
                     i_wr_data[lsc_pkg::CMD_SEL_BIT];
   assign data_wr = i_wr_stb && !first_byte;
   // word and block transfers walk through byte pairs
   assign step = (data_wr || i_rd_stb) && (cmd_word || cmd_block);
   assign clr_req = cmd_take && i_wr_data[lsc_pkg::CMD_CLEAR_BIT];
   assign wr_on_off = data_wr && hit(cmd_addr, lsc_pkg::ADDR_ON_OFF);
   assign wr_setup = data_wr && hit(cmd_addr, lsc_pkg::ADDR_SETUP);
   assign wr_lo_lsb = data_wr && hit(cmd_addr, lsc_pkg::ADDR_LO_LSB);
   assign wr_lo_msb = data_wr && hit(cmd_addr, lsc_pkg::ADDR_LO_MSB);
   assign wr_hi_lsb = data_wr && hit(cmd_addr, lsc_pkg::ADDR_HI_LSB);
   assign wr_hi_msb = data_wr && hit(cmd_addr, lsc_pkg::ADDR_HI_MSB);
   assign next_cmd_addr = cmd_take ? i_wr_data[3:0] :
                          step ? cmd_addr + 4'h1 : cmd_addr;

   assign on_off_byte = {6'h00, power};
   assign setup_byte = {3'h0, gain, manual, 1'b0, period};
   assign rd_mux = hit(cmd_addr, lsc_pkg::ADDR_ON_OFF) ? on_off_byte :
                   hit(cmd_addr, lsc_pkg::ADDR_SETUP) ? setup_byte :
                   hit(cmd_addr, lsc_pkg::ADDR_LO_LSB) ? lo_limit[7:0] :
                   hit(cmd_addr, lsc_pkg::ADDR_LO_MSB) ? lo_limit[15:8] :
                   hit(cmd_addr, lsc_pkg::ADDR_HI_LSB) ? hi_limit[7:0] :
                   hit(cmd_addr, lsc_pkg::ADDR_HI_MSB) ? hi_limit[15:8] :
                   8'h00;

   // a new event wins over a clear in the same cycle
   assign next_int_n = intg.limit_evt ? 1'b0 :
                       clr_req ? 1'b1 : o_int_n;

   // ------------------------------------------------------------
   // command register and transaction tracking
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cmd_addr <= lsc_pkg::RST_CMD[3:0];
         cmd_word <= 1'b0;
         cmd_block <= 1'b0;
         first_byte <= 1'b0;
      end
      else if (i_ce)
      begin
         cmd_addr <= next_cmd_addr;
         if (cmd_take)
         begin
            cmd_word <= i_wr_data[lsc_pkg::CMD_WORD_BIT];
            cmd_block <= i_wr_data[lsc_pkg::CMD_BLOCK_BIT];
         end
         if (i_xfer_start)
            first_byte <= 1'b1;
         else if (i_wr_stb)
            first_byte <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control and setup registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         power <= lsc_pkg::RST_ON_OFF[1:0];
         gain <= lsc_pkg::RST_SETUP[lsc_pkg::GAIN_BIT];
         manual <= lsc_pkg::RST_SETUP[lsc_pkg::MANUAL_BIT];
         period <= lsc_pkg::RST_SETUP[1:0];
      end
      else if (i_ce)
      begin
         if (wr_on_off)
            power <= i_wr_data[1:0];
         if (wr_setup)
         begin
            gain <= i_wr_data[lsc_pkg::GAIN_BIT];
            manual <= i_wr_data[lsc_pkg::MANUAL_BIT];
            period <= i_wr_data[1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // limit registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lo_limit <= {lsc_pkg::RST_LIMIT, lsc_pkg::RST_LIMIT};
         hi_limit <= {lsc_pkg::RST_LIMIT, lsc_pkg::RST_LIMIT};
      end
      else if (i_ce)
      begin
         if (wr_lo_lsb)
            lo_limit[7:0] <= i_wr_data;
         if (wr_lo_msb)
            lo_limit[15:8] <= i_wr_data;
         if (wr_hi_lsb)
            hi_limit[7:0] <= i_wr_data;
         if (wr_hi_msb)
            hi_limit[15:8] <= i_wr_data;
      end
   end

   // ------------------------------------------------------------
   // converter result synchroniser and outputs
   // ------------------------------------------------------------
   // result is held stable by the converter around completion
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         res_s1 <= '0;
         res_s2 <= '0;
         o_rd_data <= 8'h00;
         o_int_n <= 1'b1;
         o_power_on <= 1'b0;
         o_gain_high <= 1'b0;
         o_integrating <= 1'b0;
      end
      else if (i_ce)
      begin
         res_s1 <= i_ch0_result;
         res_s2 <= res_s1;
         if (i_rd_stb)
            o_rd_data <= rd_mux;
         o_int_n <= next_int_n;
         o_power_on <= power == lsc_pkg::POWER_UP;
         o_gain_high <= gain;
         o_integrating <= intg.running;
      end
   end

   // ------------------------------------------------------------
   // integration and comparison
   // ------------------------------------------------------------
   assign intg.power_on = power == lsc_pkg::POWER_UP;
   assign intg.period_sel = period;
   assign intg.manual = manual;
   assign intg.result = res_s2;
   assign intg.lo_limit = lo_limit;
   assign intg.hi_limit = hi_limit;

   lsc_intg_timer #(
      .CYC_SHORT(CYC_SHORT),
      .CYC_MID(CYC_MID),
      .CYC_LONG(CYC_LONG)
   ) u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .bus(intg.timer)
   );

   lsc_limit_cmp u_cmp (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .bus(intg.cmp)
   );

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   // checks pause while the clock enable freezes the state
   default disable iff (!i_rst_n || !i_ce);

   sequence s_power_write;
      wr_on_off && i_wr_data[1:0] == lsc_pkg::POWER_UP;
   endsequence
   sequence s_manual_start;
      wr_setup && i_wr_data[1:0] == lsc_pkg::PERIOD_MANUAL &&
      i_wr_data[lsc_pkg::MANUAL_BIT] && !manual &&
      power == lsc_pkg::POWER_UP && !intg.running;
   endsequence

   power_up_a: assert property (s_power_write |=> ##1 o_power_on)
      else $error("power up write did not power the device");
   power_down_a: assert property ((power == lsc_pkg::POWER_DOWN)[*3]
      |-> !o_integrating && !intg.done)
      else $error("integration active while powered down");
   readback_a: assert property (i_rd_stb && !i_wr_stb &&
      hit(cmd_addr, lsc_pkg::ADDR_ON_OFF) && power == lsc_pkg::POWER_UP
      |=> o_rd_data == 8'h03)
      else $error("control register did not read back 03h");
   manual_start_a: assert property (s_manual_start |=> ##2 o_integrating
      [*2])
      else $error("manual start did not begin integration");
   manual_ignore_a: assert property (intg.running && period !=
      lsc_pkg::PERIOD_MANUAL && $fell(manual) && power == lsc_pkg::POWER_UP
      |=> intg.running)
      else $error("manual bit acted outside manual code");
   low_limit_a: assert property (intg.done && res_s2 <= lo_limit
      |=> intg.limit_evt ##1 !o_int_n)
      else $error("low limit event missed");
   high_limit_a: assert property (intg.done && res_s2 > hi_limit
      |=> intg.limit_evt ##1 !o_int_n)
      else $error("high limit event missed");
   int_clear_a: assert property (clr_req && !intg.limit_evt && !o_int_n
      |=> o_int_n)
      else $error("interrupt clear ignored");
   cmd_addr_a: assert property (cmd_take |=> cmd_addr ==
      $past(i_wr_data[3:0]))
      else $error("command byte not stored as address");
   limit_pair_a: assert property (wr_lo_msb |=> lo_limit[15:8] ==
      $past(i_wr_data))
      else $error("lower limit high byte not written");
   power_off_a: assert property (wr_on_off &&
      i_wr_data[1:0] == lsc_pkg::POWER_DOWN |=> ##1 !o_power_on)
      else $error("power down write did not power off");
   gain_follow_a: assert property (wr_setup |=> ##1 o_gain_high ==
      $past(i_wr_data[lsc_pkg::GAIN_BIT], 2))
      else $error("gain output does not follow setup write");
   int_hold_a: assert property (!o_int_n && !clr_req |=> !o_int_n)
      else $error("interrupt released without clear");
   cmd_refuse_a: assert property (i_wr_stb && !i_rd_stb && first_byte &&
      !i_wr_data[lsc_pkg::CMD_SEL_BIT] |=> $stable(cmd_addr))
      else $error("byte without select flag stored as address");
endmodule : lsc_light_ctrl

// ===== testbench/lsc_host_model.sv
// lsc_host_model: host side driver of the light sensor register port
`timescale 1ns/1ps
module lsc_host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rd_data,
   output logic o_xfer_start,
   output logic o_wr_stb,
   output logic [7:0] o_wr_data,
   output logic o_rd_stb
);
   initial
   begin
      o_xfer_start = 1'b0;
      o_wr_stb = 1'b0;
      o_wr_data = 8'h00;
      o_rd_stb = 1'b0;
   end
   // ------------------------------------------------------------
   // byte level steps
   // ------------------------------------------------------------
   // released data shows the inverse so a stale byte is never reused
   task automatic put(input logic [7:0] d);
      @(negedge i_clk);
      o_wr_stb = 1'b1;
      o_wr_data = d;
      @(negedge i_clk);
      o_wr_stb = 1'b0;
      o_wr_data = ~d;
   endtask : put
   task automatic get(output logic [7:0] d);
      @(negedge i_clk);
      o_rd_stb = 1'b1;
      @(negedge i_clk);
      o_rd_stb = 1'b0;
      @(negedge i_clk);
      d = i_rd_data;
   endtask : get
   task automatic send_cmd(input logic [7:0] c);
      @(negedge i_clk);
      o_xfer_start = 1'b1;
      @(negedge i_clk);
      o_xfer_start = 1'b0;
      o_wr_stb = 1'b1;
      o_wr_data = c;
      @(negedge i_clk);
      o_wr_stb = 1'b0;
      o_wr_data = ~c;
   endtask : send_cmd
   // ------------------------------------------------------------
   // register transactions
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      send_cmd({4'h8, a});
      put(d);
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      send_cmd({4'h8, a});
      get(d);
   endtask : rd_reg
   // limit pairs are always written as one word, lsb first
   task automatic wr_word(input logic [3:0] a, input logic [15:0] w);
      send_cmd({4'ha, a});
      put(w[7:0]);
      put(w[15:8]);
   endtask : wr_word
   task automatic rd_word(input logic [3:0] a, output logic [15:0] w);
      send_cmd({4'ha, a});
      get(w[7:0]);
      get(w[15:8]);
   endtask : rd_word
endmodule : lsc_host_model

// ===== testbench/light_sensor_ctrl_thresholds_tb.sv
// light_sensor_ctrl_thresholds_tb: register and threshold tests
`timescale 1ns/1ps
module light_sensor_ctrl_thresholds_tb;
   localparam int CS = 20;
   localparam int CM = 40;
   localparam int CL = 80;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic ce = 1'b1;
   logic [15:0] ch0 = 16'h0000;
   logic xfer_start, wr_stb, rd_stb, int_n, power_on, gain_high, period_select;
   logic [7:0] wr_data, rd_data, d;
   logic [15:0] w;
   logic [7:0] rst_tab [8] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
   int cyc_tab [3] = '{CS, CM, CL};
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;
   int t0;
   always #25 i_clk = ~i_clk;
   lsc_light_ctrl #(.CYC_SHORT(CS), .CYC_MID(CM), .CYC_LONG(CL))
   lsc_light_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
      .i_xfer_start(xfer_start), .i_wr_stb(wr_stb), .i_wr_data(wr_data),
      .i_rd_stb(rd_stb), .i_ch0_result(ch0), .o_rd_data(rd_data),
      .o_int_n(int_n), .o_power_on(power_on), .o_gain_high(gain_high),
      .o_integrating(period_select));
   lsc_host_model lsc_host_model_i (.i_clk(i_clk), .i_rd_data(rd_data),
      .o_xfer_start(xfer_start), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
      .o_rd_stb(rd_stb));
   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk8
   task automatic chk1(input string n, input logic e, input logic g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask : chk1
   task automatic chk_rng(input string n, input int lo, input int hi, input int g);
      n_compared++;
      if (g < lo || g > hi)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask : chk_rng
   // bounded wait; a miss shows up as a mismatch on the level itself
   task automatic wait_int(input logic v, input int n);
      for (int k = 0; k < n && int_n !== v; k++)
         @(negedge i_clk);
      chk1("o_int_n", v, int_n);
   endtask : wait_int
   task automatic clear_int();
      lsc_host_model_i.send_cmd(8'hc0);
      wait_int(1'b1, 4);
   endtask : clear_int
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      chk1("o_int_n", 1'b1, int_n);
      chk1("o_power_on", 1'b0, power_on);
      for (int a = 0; a < 8; a++)
      begin
         lsc_host_model_i.rd_reg(a[3:0], d);
         chk8($sformatf("reg %0d", a), rst_tab[a], d);
      end
      lsc_host_model_i.rd_reg(4'hf, d);
      chk8("reg 15", 8'h00, d);
      $display("test reset values done");
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_ON_OFF, 8'h03);
      lsc_host_model_i.rd_reg(lsc_pkg::ADDR_ON_OFF, d);
      chk8("on_off", 8'h03, d);
      chk1("o_power_on", 1'b1, power_on);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_ON_OFF, 8'h00);
      repeat (3) @(negedge i_clk);
      chk1("o_power_on", 1'b0, power_on);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h12);
      lsc_host_model_i.rd_reg(lsc_pkg::ADDR_SETUP, d);
      chk8("setup", 8'h12, d);
      chk1("o_gain_high", 1'b1, gain_high);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h02);
      repeat (3) @(negedge i_clk);
      chk1("o_gain_high", 1'b0, gain_high);
      $display("test power and gain done");
      lsc_host_model_i.wr_word(lsc_pkg::ADDR_LO_LSB, 16'h0100);
      lsc_host_model_i.wr_word(lsc_pkg::ADDR_HI_LSB, 16'h0200);
      lsc_host_model_i.rd_word(lsc_pkg::ADDR_LO_LSB, w);
      chk8("lower lsb", 8'h00, w[7:0]);
      chk8("lower msb", 8'h01, w[15:8]);
      lsc_host_model_i.rd_word(lsc_pkg::ADDR_HI_LSB, w);
      chk8("upper lsb", 8'h00, w[7:0]);
      chk8("upper msb", 8'h02, w[15:8]);
      // a block read walks 2h..5h in one transaction
      lsc_host_model_i.send_cmd(8'h92);
      for (int a = 2; a < 6; a++)
      begin
         lsc_host_model_i.get(d);
         chk8($sformatf("block reg %0d", a), 8'(a[0] ? a / 2 : 0),
            d);
      end
      // a lone byte with bit 7 set only moves the address
      lsc_host_model_i.send_cmd(8'h85);
      lsc_host_model_i.send_cmd(8'h04);
      lsc_host_model_i.get(d);
      chk8("addressed read", 8'h02, d);
      $display("test limits done");
      ch0 = 16'h0101;
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h00);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_ON_OFF, 8'h03);
      repeat (60) @(negedge i_clk);
      chk1("o_int_n", 1'b1, int_n);
      ch0 = 16'h0100;
      wait_int(1'b0, 60);
      ch0 = 16'h0200;
      clear_int();
      repeat (60) @(negedge i_clk);
      chk1("o_int_n", 1'b1, int_n);
      ch0 = 16'h0201;
      wait_int(1'b0, 60);
      ch0 = 16'h0150;
      repeat (60) @(negedge i_clk);
      chk1("o_int_n", 1'b0, int_n);
      $display("test thresholds done");
      ch0 = 16'h0000;
      for (int c = 0; c < 3; c++)
      begin
         lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, c[7:0]);
         clear_int();
         wait_int(1'b0, 400);
         t0 = cyc;
         clear_int();
         wait_int(1'b0, 400);
         chk_rng("period", cyc_tab[c], cyc_tab[c] + 2, cyc - t0);
      end
      $display("test periods done");
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_ON_OFF, 8'h00);
      clear_int();
      repeat (100) @(negedge i_clk);
      chk1("o_int_n", 1'b1, int_n);
      chk1("o_integrating", 1'b0, period_select);
      lsc_host_model_i.rd_reg(lsc_pkg::ADDR_LO_MSB, d);
      chk8("lower msb", 8'h01, d);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h03);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_ON_OFF, 8'h03);
      repeat (100) @(negedge i_clk);
      chk1("o_integrating", 1'b0, period_select);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h0b);
      repeat (4) @(negedge i_clk);
      chk1("o_integrating", 1'b1, period_select);
      repeat (150) @(negedge i_clk);
      chk1("o_integrating", 1'b1, period_select);
      chk1("o_int_n", 1'b1, int_n);
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h03);
      wait_int(1'b0, 8);
      chk1("o_integrating", 1'b0, period_select);
      clear_int();
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h08);
      wait_int(1'b0, 60);
      clear_int();
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_SETUP, 8'h00);
      chk1("o_integrating", 1'b1, period_select);
      wait_int(1'b0, 60);
      // with the clock enable low a whole write must be lost
      ce = 1'b0;
      lsc_host_model_i.wr_reg(lsc_pkg::ADDR_ON_OFF, 8'h00);
      ce = 1'b1;
      lsc_host_model_i.rd_reg(lsc_pkg::ADDR_ON_OFF, d);
      chk8("on_off frozen", 8'h03, d);
      $display("test power down and manual done");
      conclude();
   end
endmodule : light_sensor_ctrl_thresholds_tb
